// *** crq_consts.svh ***
`ifndef CRQ_CONSTS_SVH
`define CRQ_CONSTS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CRQ_ADDR_CTRL      12'h000
`define CRQ_ADDR_TIMING    12'h004
`define CRQ_ADDR_STATUS    12'h008
`define CRQ_ADDR_FREQ      12'h00c
`define CRQ_ADDR_CALIB     12'h010

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CRQ_CTRL_OUT1_OD   0
`define CRQ_CTRL_OUT2_OD   1
`define CRQ_CTRL_FM_FAST   2
`define CRQ_CTRL_XTAL      3
`define CRQ_CTRL_SLOW32K   4
`define CRQ_TIM_LEAD_LSB   0
`define CRQ_TIM_SETTLE_LSB 8
`define CRQ_CALIB_START    0
`define CRQ_CTRL_RST       5'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define CRQ_CLK_HZ         25000000
`define CRQ_CYC_PER_MS     (`CRQ_CLK_HZ / 1000)
`define CRQ_BOOT_TIME_MS   30
`define CRQ_LEAD_TIME_MS   30
`define CRQ_SETTLE_TIME_MS 15

// ----------------------------------------
// frequency detection windows and thresholds
// ----------------------------------------
`define CRQ_FAST_WIN       16'h8000
`define CRQ_SLOW_WIN       16'h0020
`define CRQ_CALIB_WIN      16'h0100
`define CRQ_SLOW_THR       20'h0_6083
`define CRQ_FTHR_0         20'h0_0129
`define CRQ_FTHR_1         20'h0_0150
`define CRQ_FTHR_2         20'h0_0171
`define CRQ_FTHR_3         20'h0_01cc
`define CRQ_FTHR_4         20'h0_0252
`define CRQ_FTHR_5         20'h0_02a0
`define CRQ_FTHR_6         20'h0_02e1
`define CRQ_FTHR_7         20'h0_039e

`endif

// *** crq_meter.sv ***
`timescale 1ns/100ps
`default_nettype none
module crq_meter
   import crq_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        start,
   input  wire logic        tick,
   input  wire logic        event_in,
   input  wire logic [15:0] window,
   output logic      [19:0] count,
   output logic             busy,
   output logic             done
);
   crq_meter_st_t q;
   crq_meter_st_t next_q;

   // counting starts at the first tick so a partial window is never seen
   always_comb
   begin
      next_q = q;
      if (start)
      begin
         next_q.armed = 1'b1;
         next_q.busy  = 1'b0;
         next_q.done  = 1'b0;
         next_q.cnt   = 20'h0_0000;
         next_q.win   = window;
      end
      else if (q.armed && tick)
      begin
         next_q.armed = 1'b0;
         next_q.busy  = 1'b1;
      end
      else if (q.busy)
      begin
         if (event_in && q.cnt != 20'hf_ffff)
         begin
            next_q.cnt = q.cnt + 20'h0_0001;
         end
         if (tick)
         begin
            if (q.win <= 16'h0001)
            begin
               next_q.busy = 1'b0;
               next_q.done = 1'b1;
            end
            else
            begin
               next_q.win = q.win - 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= next_q;
      end
   end

   assign count = q.cnt;
   assign busy  = q.busy | q.armed;
   assign done  = q.done;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   meter_done_a: assert property ($rose(q.done) |-> $past(q.busy) && $past(tick))
      else $error("meter finished without a closing tick");
endmodule : crq_meter
`default_nettype wire

// *** crq_pkg.sv ***
`default_nettype none
package crq_pkg;

   typedef enum logic [2:0]
   {
      crq_st_reset  = 3'b000,
      crq_st_boot   = 3'b001,
      crq_st_lead   = 3'b010,
      crq_st_settle = 3'b011,
      crq_st_detect = 3'b100,
      crq_st_run    = 3'b101
   } crq_state_t;

   typedef struct packed
   {
      logic        armed;
      logic        busy;
      logic        done;
      logic [15:0] win;
      logic [19:0] cnt;
   } crq_meter_st_t;

   typedef struct packed
   {
      crq_state_t  state;
      logic [19:0] ms_pre;
      logic [4:0]  ms_cnt;
      logic [4:0]  reg_high_ms;
      logic        slow_d;
      logic        fmon_d;
      logic        ext_req;
      logic        own_req;
      logic        reg_mode;
      logic        fast_usable;
      logic        det_go;
      logic        det_done;
      logic        calib_go;
      logic        out1_od;
      logic        out2_od;
      logic        fm_on_fast;
      logic        xtal_mode;
      logic        slow_confirm;
      logic [4:0]  lead_ms;
      logic [4:0]  settle_ms;
      logic [3:0]  fast_idx;
      logic [10:0] fast_raw;
      logic        slow_32k;
      logic        req_hi_out;
      logic        req_hi_oe;
      logic        req_n_out;
      logic        req_n_oe;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } crq_top_st_t;

endpackage : crq_pkg
`default_nettype wire

// *** crq_plat_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module crq_plat_model
#(
   parameter int SLOW_HALF_NS = 15259,
   parameter int FAST_HALF_NS = 1231
)
(
   output logic     slow_clock_input,
   output logic     fast_clock_monitor,
   output logic     hardware_reset_n,
   input  wire logic clk_req_hi_out
);
   // ----------------------------------------
   // slow clock free running, reset pin
   // ----------------------------------------
   initial
   begin
      slow_clock_input = 1'b0;
      fast_clock_monitor = 1'b0;
      hardware_reset_n = 1'b0;
      repeat (3) @(posedge slow_clock_input);
      hardware_reset_n = 1'b1;
   end

   always #(SLOW_HALF_NS) slow_clock_input = ~slow_clock_input;

   // ----------------------------------------
   // fast clock only while requested
   // ----------------------------------------
   // follows the active high pin only, so runs with the active high pin open drain see no fast clock
   always #(FAST_HALF_NS) fast_clock_monitor = clk_req_hi_out & ~fast_clock_monitor;
endmodule : crq_plat_model
`default_nettype wire

// *** crq_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module crq_sync
#(
   parameter int WIDTH = 7
)
(
   input  wire logic [WIDTH-1:0] clk_d,
   input  wire logic             clk,
   input  wire logic             rst,
   output logic      [WIDTH-1:0] sync_q
);
   typedef struct packed
   {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } crq_sync_st_t;

   crq_sync_st_t q;
   crq_sync_st_t next_q;

   if (WIDTH < 1)
   begin : g_chk
      $error("crq_sync: WIDTH must be at least 1");
   end

   always_comb
   begin
      next_q    = q;
      next_q.s1 = clk_d;
      next_q.s2 = q.s1;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= next_q;
      end
   end

   assign sync_q = q.s2;
endmodule : crq_sync
`default_nettype wire

// *** crq_top.sv ***
`include "crq_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module crq_top
   import crq_pkg::*;
#(
   parameter int CYC_PER_MS = `CRQ_CYC_PER_MS
)
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        hardware_reset_n,
   input  wire logic        slow_clock_input,
   input  wire logic        clk_req_in,
   input  wire logic        fast_clock_monitor,
   input  wire logic        core_supplies_ok,
   input  wire logic        digital_core_supply_ok,
   input  wire logic        io_supply_ok,
   input  wire logic        bt_clk_need,
   input  wire logic        fm_clk_need,
   input  wire logic        bt_low_power,
   input  wire logic        fm_low_power,
   output logic             clk_req_hi_out,
   output logic             clk_req_hi_oe,
   output logic             clk_req_n_out,
   output logic             clk_req_n_oe,
   output logic             reg_mode_out,
   output logic             fast_clock_usable
);
   // ----------------------------------------
   // state and pin synchronisers
   // ----------------------------------------
   crq_top_st_t q;
   crq_top_st_t next_q;
   logic [6:0]  pins_s;
   logic        hrn_s;
   logic        slow_s;
   logic        ext_s;
   logic        fmon_s;
   logic        core_ok_s;
   logic        dig_ok_s;
   logic        io_ok_s;
   logic [19:0] fast_cnt;
   logic [19:0] slow_cnt;
   logic [19:0] cal_cnt;
   logic        fast_done;
   logic        slow_done;
   logic        cal_busy;
   logic        slow_rise;
   logic        fmon_rise;
   logic        ms_tick;
   logic        hw_rst_act;
   logic        own_need;
   logic        lead_ok;
   logic        req_any;
   logic        drive_en;
   logic        addr_hit;
   logic [31:0] rd_data;

   if (CYC_PER_MS < 2 || CYC_PER_MS > 1048575)
   begin : g_chk
      $error("crq_top: CYC_PER_MS out of range");
   end

   crq_sync #(.WIDTH(7)) u_sync
   (
      .clk_d  ({hardware_reset_n, slow_clock_input, clk_req_in, fast_clock_monitor,
                core_supplies_ok, digital_core_supply_ok, io_supply_ok}),
      .clk    (clk),
      .rst    (rst),
      .sync_q (pins_s)
   );
   assign {hrn_s, slow_s, ext_s, fmon_s, core_ok_s, dig_ok_s, io_ok_s} = pins_s;

   // ----------------------------------------
   // frequency meters
   // ----------------------------------------
   crq_meter u_fast
   (
      .clk      (clk),
      .rst      (rst),
      .start    (q.det_go),
      .tick     (1'b1),
      .event_in (fmon_rise),
      .window   (`CRQ_FAST_WIN),
      .count    (fast_cnt),
      .busy     (),
      .done     (fast_done)
   );

   crq_meter u_slow
   (
      .clk      (clk),
      .rst      (rst),
      .start    (q.det_go),
      .tick     (slow_rise),
      .event_in (1'b1),
      .window   (`CRQ_SLOW_WIN),
      .count    (slow_cnt),
      .busy     (),
      .done     (slow_done)
   );

   crq_meter u_calib
   (
      .clk      (clk),
      .rst      (rst),
      .start    (q.calib_go),
      .tick     (slow_rise),
      .event_in (fmon_rise),
      .window   (`CRQ_CALIB_WIN),
      .count    (cal_cnt),
      .busy     (cal_busy),
      .done     ()
   );

   // nearest of the nine supported rates, count taken over the fast window
   function automatic logic [3:0] crq_classify(input logic [19:0] c);
      logic [3:0] idx;
      idx = 4'h0;
      if (c > `CRQ_FTHR_0) idx = 4'h1;
      if (c > `CRQ_FTHR_1) idx = 4'h2;
      if (c > `CRQ_FTHR_2) idx = 4'h3;
      if (c > `CRQ_FTHR_3) idx = 4'h4;
      if (c > `CRQ_FTHR_4) idx = 4'h5;
      if (c > `CRQ_FTHR_5) idx = 4'h6;
      if (c > `CRQ_FTHR_6) idx = 4'h7;
      if (c > `CRQ_FTHR_7) idx = 4'h8;
      return idx;
   endfunction : crq_classify

   assign slow_rise  = slow_s & ~q.slow_d;
   assign fmon_rise  = fmon_s & ~q.fmon_d;
   assign ms_tick    = (q.ms_pre == 20'(CYC_PER_MS - 1));
   assign hw_rst_act = ~hrn_s | ~core_ok_s | ~io_ok_s;
   assign own_need   = bt_clk_need | (q.fm_on_fast & fm_clk_need);
   assign lead_ok    = q.reg_mode && (q.reg_high_ms >= q.lead_ms);
   assign req_any    = q.own_req | q.ext_req;
   // crystal mode or no I/O supply: request pins are not used
   assign drive_en   = io_ok_s & ~q.xtal_mode;

   // ----------------------------------------
   // register read decode
   // ----------------------------------------
   always_comb
   begin
      addr_hit = 1'b1;
      rd_data  = 32'h0000_0000;
      case (paddr)
         `CRQ_ADDR_CTRL:
            rd_data[4:0] = {q.slow_confirm, q.xtal_mode, q.fm_on_fast, q.out2_od, q.out1_od};
         `CRQ_ADDR_TIMING:
            rd_data[12:0] = {q.settle_ms, 3'h0, q.lead_ms};
         `CRQ_ADDR_STATUS:
            rd_data[9:0] = {cal_busy, q.det_done, q.slow_32k | q.slow_confirm,
                            q.fast_usable, q.reg_mode, req_any, 1'b0, q.state};
         `CRQ_ADDR_FREQ:
            rd_data[26:0] = {q.fast_raw, 12'h000, q.fast_idx};
         `CRQ_ADDR_CALIB:
            rd_data[20:0] = {cal_busy, cal_cnt};
         default:
            addr_hit = 1'b0;
      endcase
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      next_q          = q;
      next_q.slow_d   = slow_s;
      next_q.fmon_d   = fmon_s;
      next_q.det_go   = 1'b0;
      next_q.calib_go = 1'b0;
      next_q.pready   = 1'b0;
      next_q.pslverr  = 1'b0;
      next_q.ms_pre   = ms_tick ? 20'h0_0000 : q.ms_pre + 20'h0_0001;

      if (!q.reg_mode)
      begin
         next_q.reg_high_ms = 5'h00;
      end
      else if (ms_tick && q.reg_high_ms != 5'h1f)
      begin
         next_q.reg_high_ms = q.reg_high_ms + 5'h01;
      end

      // resample only on slow clock edges, request flop cannot glitch
      if (slow_rise)
      begin
         next_q.ext_req = ext_s & dig_ok_s;
      end

      case (q.state)
         crq_st_reset:
         begin
            next_q.own_req     = 1'b0;
            next_q.reg_mode    = 1'b0;
            next_q.fast_usable = 1'b0;
            next_q.ms_cnt      = 5'h00;
            next_q.state       = crq_st_boot;
         end
         crq_st_boot:
         begin
            if (ms_tick)
            begin
               next_q.ms_cnt = q.ms_cnt + 5'h01;
            end
            if (q.ms_cnt >= 5'(`CRQ_BOOT_TIME_MS) - q.lead_ms)
            begin
               next_q.reg_mode = 1'b1;
               next_q.state    = crq_st_lead;
            end
         end
         crq_st_lead:
         begin
            if (lead_ok)
            begin
               next_q.own_req = 1'b1;
               next_q.ms_cnt  = 5'h00;
               next_q.state   = crq_st_settle;
            end
         end
         crq_st_settle:
         begin
            if (ms_tick)
            begin
               next_q.ms_cnt = q.ms_cnt + 5'h01;
            end
            if (q.ms_cnt >= q.settle_ms)
            begin
               next_q.fast_usable = 1'b1;
               next_q.det_go      = 1'b1;
               next_q.state       = crq_st_detect;
            end
         end
         crq_st_detect:
         begin
            if (fast_done && slow_done && !q.det_go)
            begin
               next_q.fast_idx = crq_classify(fast_cnt);
               next_q.fast_raw = fast_cnt[10:0];
               next_q.slow_32k = (slow_cnt > `CRQ_SLOW_THR);
               next_q.det_done = 1'b1;
               next_q.state    = crq_st_run;
            end
         end
         crq_st_run:
         begin
            next_q.reg_mode = ~(bt_low_power & fm_low_power) | own_need;
            next_q.own_req  = own_need & lead_ok;
         end
         default:
         begin
            next_q.state = crq_st_reset;
         end
      endcase

      if (hw_rst_act)
      begin
         next_q.state       = crq_st_reset;
         next_q.own_req     = 1'b0;
         next_q.reg_mode    = 1'b0;
         next_q.fast_usable = 1'b0;
         next_q.det_done    = 1'b0;
      end

      // pin drivers follow the request flop one cycle later
      if (!drive_en)
      begin
         next_q.req_hi_out = 1'b0;
         next_q.req_hi_oe  = 1'b0;
         next_q.req_n_out  = 1'b0;
         next_q.req_n_oe   = 1'b0;
      end
      else
      begin
         next_q.req_hi_out = q.out1_od ? 1'b0 : req_any;
         next_q.req_hi_oe  = q.out1_od ? ~req_any : 1'b1;
         next_q.req_n_out  = q.out2_od ? 1'b0 : ~req_any;
         next_q.req_n_oe   = q.out2_od ? req_any : 1'b1;
      end

      // apb: one wait state, write lands when pready is seen high
      if (psel && penable && !q.pready)
      begin
         next_q.pready  = 1'b1;
         next_q.pslverr = ~addr_hit;
         next_q.prdata  = pwrite ? 32'h0000_0000 : rd_data;
      end
      if (psel && penable && q.pready && pwrite)
      begin
         case (paddr)
            `CRQ_ADDR_CTRL:
            begin
               next_q.out1_od      = pwdata[`CRQ_CTRL_OUT1_OD];
               next_q.out2_od      = pwdata[`CRQ_CTRL_OUT2_OD];
               next_q.fm_on_fast   = pwdata[`CRQ_CTRL_FM_FAST];
               next_q.xtal_mode    = pwdata[`CRQ_CTRL_XTAL];
               next_q.slow_confirm = pwdata[`CRQ_CTRL_SLOW32K];
            end
            `CRQ_ADDR_TIMING:
            begin
               next_q.lead_ms   = (pwdata[4:0] > 5'(`CRQ_LEAD_TIME_MS)) ?
                                  5'(`CRQ_LEAD_TIME_MS) : pwdata[4:0];
               next_q.settle_ms = (pwdata[12:8] > 5'(`CRQ_SETTLE_TIME_MS)) ?
                                  5'(`CRQ_SETTLE_TIME_MS) : pwdata[12:8];
            end
            `CRQ_ADDR_CALIB:
            begin
               next_q.calib_go = pwdata[`CRQ_CALIB_START] & q.fast_usable;
            end
            default:
            begin
               next_q.calib_go = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         q           <= '0;
         q.state     <= crq_st_reset;
         q.lead_ms   <= 5'(`CRQ_LEAD_TIME_MS);
         q.settle_ms <= 5'(`CRQ_SETTLE_TIME_MS);
      end
      else
      begin
         q <= next_q;
      end
   end

   assign prdata            = q.prdata;
   assign pready            = q.pready;
   assign pslverr           = q.pslverr;
   assign clk_req_hi_out    = q.req_hi_out;
   assign clk_req_hi_oe     = q.req_hi_oe;
   assign clk_req_n_out     = q.req_n_out;
   assign clk_req_n_oe      = q.req_n_oe;
   assign reg_mode_out      = q.reg_mode;
   assign fast_clock_usable = q.fast_usable;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence boot_to_lead_s;
      q.state == crq_st_boot ##1 q.state == crq_st_lead;
   endsequence

   req_before_use_a: assert property ($rose(q.fast_usable) |-> q.own_req)
      else $error("fast clock used before it was requested");
   boot_delay_a: assert property (boot_to_lead_s |->
         $past(q.ms_cnt) >= 5'(`CRQ_BOOT_TIME_MS) - q.lead_ms)
      else $error("request phase entered before the boot delay");
   settle_wait_a: assert property ($rose(q.fast_usable) |-> $past(q.ms_cnt) >= q.settle_ms)
      else $error("fast clock used before the settle time");
   lead_order_a: assert property ($rose(q.own_req) |->
         q.reg_mode && $past(q.reg_high_ms) >= q.lead_ms)
      else $error("request rose without regulator lead");
   reg_low_lp_a: assert property ((q.state == crq_st_run && bt_low_power && fm_low_power
         && !own_need && !hw_rst_act) |=> !q.reg_mode)
      else $error("regulator mode high with both subsystems asleep");
   xtal_quiet_a: assert property (q.xtal_mode ##1 q.xtal_mode |->
         !clk_req_hi_oe && !clk_req_n_oe)
      else $error("request pin driven in crystal mode");
   polarity_a: assert property ((clk_req_hi_oe && clk_req_n_oe && !q.out1_od && !q.out2_od)
         |-> clk_req_hi_out != clk_req_n_out)
      else $error("push-pull request outputs not complementary");
   ext_prop_a: assert property ($changed(q.ext_req) |-> $past(slow_rise))
      else $error("external request changed off a slow clock edge");
   ext_follow_a: assert property ((q.ext_req && drive_en && !q.out1_od)
         |=> clk_req_hi_out)
      else $error("external request not propagated");
   supply_reset_a: assert property (hw_rst_act |=> q.state == crq_st_reset && !q.own_req)
      else $error("supply loss did not return to reset");
   no_need_a: assert property ((q.state == crq_st_run && !own_need && !hw_rst_act)
         |=> !q.own_req)
      else $error("own request held without a need");
   detect_a: assert property ($rose(q.det_done) |-> q.fast_idx == crq_classify($past(fast_cnt)))
      else $error("fast clock index does not match the count");
endmodule : crq_top
`default_nettype wire

// *** crq_top_tb_top.sv ***
`include "crq_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module crq_top_tb_top;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, e, dig_ok;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic        hardware_reset_n, slow_clock_input, fast_clock_monitor, clk_req_in;
   logic        io_supply_ok, bt_clk_need, fm_clk_need, bt_low_power, fm_low_power;
   logic        clk_req_hi_out, clk_req_hi_oe, clk_req_n_out, clk_req_n_oe;
   logic        reg_mode_out, fast_clock_usable;
   int          miscompares, n_checks, cyc, n;

   crq_top #(.CYC_PER_MS(20)) dut_u
   (
      .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .hardware_reset_n, .slow_clock_input, .clk_req_in, .fast_clock_monitor,
      .core_supplies_ok(io_supply_ok), .digital_core_supply_ok(dig_ok), .io_supply_ok,
      .bt_clk_need, .fm_clk_need, .bt_low_power, .fm_low_power, .clk_req_hi_out,
      .clk_req_hi_oe, .clk_req_n_out, .clk_req_n_oe, .reg_mode_out, .fast_clock_usable
   );

   crq_plat_model plat_u
   (
      .slow_clock_input, .fast_clock_monitor, .hardware_reset_n, .clk_req_hi_out
   );

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
      n_checks++;
      if (y !== x)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, x, y);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_req(input logic v);
      n = 0;
      while (clk_req_hi_out !== v && n < 3000)
      begin
         @(posedge clk);
         n++;
      end
   endtask : wait_req

   task automatic settle(input int x);
      wait_req(1'b1);
      n = 0;
      while (fast_clock_usable !== 1'b1 && n < 3000)
      begin
         @(posedge clk);
         n++;
      end
      // ms ticks run free, so the first one may come up to a full ms early
      chk("settle", 1, n inside {[x-20:x+2]});
   endtask : settle

   function automatic logic [3:0] pins(input logic [1:0] m, input logic r);
      return {m[0] ? {1'b0, ~r} : {r, 1'b1}, m[1] ? {1'b0, r} : {~r, 1'b1}};
   endfunction : pins

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      apb(0, `CRQ_ADDR_TIMING, 0);
      chk("timing", 32'h0000_0f1e, q);
      apb(0, 12'h020, 0);
      chk("unmapped", 32'h0000_0001, {q[30:0], e});
      $display("regs done");
   endtask : t_regs

   task automatic t_start();
      wait (hardware_reset_n === 1'b1);
      wait_req(1'b1);
      chk("boot", 1, n inside {[580:620]});
      chk("early use", 0, fast_clock_usable);
      settle(300);
      $display("start done");
   endtask : t_start

   task automatic t_modes();
      do apb(0, `CRQ_ADDR_STATUS, 0); while (q[2:0] !== 3'd5);
      for (int m = 0; m < 4; m++)
         for (int r = 0; r < 2; r++)
         begin
            bt_clk_need <= r[0];
            apb(1, `CRQ_ADDR_CTRL, m);
            repeat (4) @(posedge clk);
            chk("pins", pins(m[1:0], r[0]),
                {clk_req_hi_out, clk_req_hi_oe, clk_req_n_out, clk_req_n_oe});
         end
      for (int f = 0; f < 2; f++)
      begin
         bt_clk_need <= 1'b0;
         fm_clk_need <= 1'b1;
         apb(1, `CRQ_ADDR_CTRL, f << 2);
         repeat (4) @(posedge clk);
         chk("fm req", f, clk_req_hi_out);
      end
      fm_clk_need <= 1'b0;
      $display("modes done");
   endtask : t_modes

   task automatic t_ext();
      apb(1, `CRQ_ADDR_CTRL, 0);
      for (int v = 1; v >= 0; v--)
      begin
         clk_req_in <= v[0];
         wait_req(v[0]);
         chk("ext", {v[0], ~v[0]}, {clk_req_hi_out, clk_req_n_out});
      end
      // without digital core supply the external request must not propagate
      dig_ok <= 1'b0;
      clk_req_in <= 1'b1;
      repeat (1600) @(posedge clk);
      chk("ext no core", 0, clk_req_hi_out);
      clk_req_in <= 1'b0;
      dig_ok <= 1'b1;
      repeat (1600) @(posedge clk);
      for (int c = 0; c < 4; c++)
      begin
         {bt_low_power, fm_low_power} <= c[1:0];
         repeat (4) @(posedge clk);
         chk("reg mode", c != 3, reg_mode_out);
      end
      $display("ext done");
   endtask : t_ext

   task automatic t_loss();
      bt_clk_need <= 1'b1;
      apb(1, `CRQ_ADDR_CTRL, 32'h0000_0008);
      repeat (4) @(posedge clk);
      chk("xtal oe", 0, {clk_req_hi_oe, clk_req_n_oe});
      bt_clk_need <= 1'b0;
      apb(1, `CRQ_ADDR_CTRL, 0);
      apb(1, `CRQ_ADDR_TIMING, 32'h0000_051e);
      io_supply_ok <= 1'b0;
      repeat (6) @(posedge clk);
      chk("loss", 0, {fast_clock_usable, clk_req_hi_oe, clk_req_n_oe});
      io_supply_ok <= 1'b1;
      settle(100);
      $display("loss done");
   endtask : t_loss

   // ----------------------------------------
   // clock, timeout, main
   // ----------------------------------------
   always #20 clk = ~clk;

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 95000)
      begin
         miscompares++;
         conclude();
      end
   end

   initial
   begin
      {clk, psel, penable, pwrite, clk_req_in, fm_clk_need, bt_low_power, fm_low_power} = '0;
      {rst, io_supply_ok, bt_clk_need, dig_ok} = '1;
      paddr = '0;
      pwdata = '0;
      repeat (12) @(posedge clk);
      chk("in reset", 0, {pready, clk_req_hi_oe, clk_req_n_oe, fast_clock_usable});
      rst <= 1'b0;
      t_regs();
      t_start();
      t_modes();
      t_ext();
      t_loss();
      conclude();
   end
endmodule : crq_top_tb_top
`default_nettype wire
